//--- core/tccu_top.sv
// The address map and register access over AXI4-Lite are this design's own decisions.
`timescale 1ns/100ps
// Notes on behaviour
// - free-running 16-bit counter; input a rise captures zero
// - capture zero raises capture-zero interrupt
// - toggle bits 11 invert flip-flop on either match alone; coincident matches cancel
// - optional flip-flop inversion on capture zero
// - external pin may clock the counter
// - mode 11 captures on gating timer edges
// - input a rise/fall capture zero/one
// - capture-one interrupt on input a fall
// - input b rise captures one, interrupts
// - event mode counts external rising edges
// - double buffer loads compare zero on match one
module tccu_top
  import tccu_pkg::*;
(
  input  wire logic        aclk,
  input  wire logic        aresetn,
  // axi4-lite write address
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  // axi4-lite write data
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  // axi4-lite write response
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  // axi4-lite read address
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  // axi4-lite read data
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  // pins
  input  wire logic        capture_input_a,
  input  wire logic        capture_input_b,
  input  wire logic        event_count_input,
  input  wire logic        gating_timer_output,
  output logic             output_flipflop,
  output logic             irq
);

  // whole state of the block
  typedef struct packed {
    tccu_wst_t   wst;
    tccu_rst_t   rst;
    logic        aw_got;
    logic        w_got;
    logic [7:0]  waddr;
    logic [31:0] wdata;
    logic [3:0]  wstrb;
    logic [1:0]  bresp;
    logic [31:0] rdata;
    logic [1:0]  rresp;
    logic [7:0]  pdiv;
    logic [15:0] up_counter;
    logic [2:0]  ctrl;
    logic [2:0]  timer_mode_reg;
    logic [2:0]  flipflop_control;
    logic [15:0] compare_reg_zero;
    logic [15:0] compare_reg_one;
    logic [15:0] cmp0_buf;
    logic [15:0] capture_reg_zero;
    logic [15:0] capture_reg_one;
    logic [TCCU_NIRQ-1:0] status;
    logic [TCCU_NIRQ-1:0] mask;
    logic        ff;
    logic        irq;
  } tccu_st_t;

  tccu_st_t   st_r;
  tccu_st_t   st_nxt;
  tccu_pins_t pins_in;    // raw pin bundle
  tccu_pins_t pins_rise;  // one-cycle rising edges
  tccu_pins_t pins_fall;  // one-cycle falling edges

  // apply byte strobes onto a register value
  function automatic logic [31:0] tccu_merge(input logic [31:0] old, input logic [31:0] nw,
                                             input logic [3:0] strb);
    logic [31:0] res;
    res = old;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        res[i*8 +: 8] = nw[i*8 +: 8];
      end
    end
    return res;
  endfunction

  // decode: true for a mapped offset
  function automatic logic tccu_mapped(input logic [7:0] a);
    case (a)
      TCCU_OFF_CTRL, TCCU_OFF_MODE, TCCU_OFF_FFCTRL, TCCU_OFF_CMP0, TCCU_OFF_CMP1,
      TCCU_OFF_CAP0, TCCU_OFF_CAP1, TCCU_OFF_COUNT, TCCU_OFF_STATUS, TCCU_OFF_MASK,
      TCCU_OFF_CMP0BUF: return 1'b1;
      default: return 1'b0;
    endcase
  endfunction

  assign pins_in = '{a: capture_input_a, b: capture_input_b, evt: event_count_input,
                     gate: gating_timer_output};

  // pins cross into aclk before anyone looks at them
  tccu_sync u_sync (
    .aclk      (aclk),
    .aresetn   (aresetn),
    .pins_in   (pins_in),
    .pins_sync (),
    .pins_rise (pins_rise),
    .pins_fall (pins_fall)
  );

  // main next-state logic: bus slave, counter, capture, compare, interrupts
  always_comb begin
    logic        tick;
    logic        match0;
    logic        match1;
    tccu_capev_t cev;
    tccu_cpm_t   cpm;
    logic [31:0] mrg;
    logic [31:0] rd;
    logic [TCCU_NIRQ-1:0] ev;
    logic        rd_status;
    tick      = 1'b0;
    match0    = 1'b0;
    match1    = 1'b0;
    cev       = '0;
    mrg       = '0;
    rd        = '0;
    ev        = '0;
    rd_status = 1'b0;
    st_nxt    = st_r;
    cpm       = tccu_cpm_t'(st_r.timer_mode_reg[TCCU_MODE_CPM_LO +: 2]);

    // count tick: prescaler enable or external rising edge
    if (st_r.pdiv == TCCU_PRESC_DIV - 8'h01) begin
      st_nxt.pdiv = '0;
    end else begin
      st_nxt.pdiv = st_r.pdiv + 8'h01;
    end
    if (st_r.ctrl[TCCU_CTRL_RUN]) begin
      if (st_r.timer_mode_reg[TCCU_MODE_EXTCLK]) begin
        tick = pins_rise.evt;
      end else begin
        tick = (st_r.pdiv == TCCU_PRESC_DIV - 8'h01);
      end
    end

    // compare matches fire on the tick that enters the matching value
    if (tick) begin
      st_nxt.up_counter = st_r.up_counter + 16'h0001;
      match0 = (st_r.up_counter + 16'h0001) == st_r.compare_reg_zero;
      match1 = (st_r.up_counter + 16'h0001) == st_r.compare_reg_one;
    end

    // capture sources by mode
    case (cpm)
      TCCU_CPM_A_UP: begin
        cev.cap0 = pins_rise.a;
        cev.cap1 = pins_rise.b;
      end
      TCCU_CPM_A_BOTH: begin
        cev.cap0 = pins_rise.a;
        cev.cap1 = pins_fall.a;
      end
      TCCU_CPM_GATE: begin
        cev.cap0 = pins_rise.gate;
        cev.cap1 = pins_fall.gate;
      end
      default: begin
        cev = '0;
      end
    endcase
    // latch the settled count, never a half-updated one
    if (cev.cap0) begin
      st_nxt.capture_reg_zero = st_r.up_counter;
    end
    if (cev.cap1) begin
      st_nxt.capture_reg_one = st_r.up_counter;
    end

    // output flip-flop: toggles when an odd number of enabled matches and toggle-enabled capture zero events fall in one cycle
    if ((match0 && st_r.flipflop_control[TCCU_FF_T0]) ^ (match1 && st_r.flipflop_control[TCCU_FF_T1])
        ^ (cev.cap0 && st_r.flipflop_control[TCCU_FF_TCAP])) begin
      st_nxt.ff = ~st_r.ff;
    end

    // double buffer shifts into compare zero on match one
    if (match1 && st_r.ctrl[TCCU_CTRL_DBUF]) begin
      st_nxt.compare_reg_zero = st_r.cmp0_buf;
    end

    ev[TCCU_IRQ_CAP0]  = cev.cap0;
    ev[TCCU_IRQ_CAP1]  = cev.cap1;
    ev[TCCU_IRQ_MATCH] = match1;

    // ---- write channel: take address and data in either order
    if (s_axi_awvalid && !st_r.aw_got && st_r.wst == TCCU_W_IDLE) begin
      st_nxt.aw_got = 1'b1;
      st_nxt.waddr  = s_axi_awaddr;
    end
    if (s_axi_wvalid && !st_r.w_got && st_r.wst == TCCU_W_IDLE) begin
      st_nxt.w_got = 1'b1;
      st_nxt.wdata = s_axi_wdata;
      st_nxt.wstrb = s_axi_wstrb;
    end
    case (st_r.wst)
      TCCU_W_IDLE: begin
        if (st_r.aw_got && st_r.w_got) begin
          st_nxt.aw_got = 1'b0;
          st_nxt.w_got  = 1'b0;
          st_nxt.wst    = TCCU_W_RESP;
          st_nxt.bresp  = tccu_mapped(st_r.waddr) ? TCCU_RESP_OKAY : TCCU_RESP_SLVERR;
          case (st_r.waddr)
            TCCU_OFF_CTRL: begin
              mrg = tccu_merge(32'(st_r.ctrl), st_r.wdata, st_r.wstrb);
              st_nxt.ctrl = mrg[2:0];
              // software capture into capture zero, self clearing
              if (mrg[TCCU_CTRL_SWCAP]) begin
                st_nxt.capture_reg_zero = st_r.up_counter;
                st_nxt.ctrl[TCCU_CTRL_SWCAP] = 1'b0;
              end
            end
            TCCU_OFF_MODE: begin
              mrg = tccu_merge(32'(st_r.timer_mode_reg), st_r.wdata, st_r.wstrb);
              st_nxt.timer_mode_reg = mrg[2:0];
            end
            TCCU_OFF_FFCTRL: begin
              mrg = tccu_merge(32'(st_r.flipflop_control), st_r.wdata, st_r.wstrb);
              st_nxt.flipflop_control = mrg[2:0];
              // force bits load the flip-flop, clear wins over set
              if (mrg[TCCU_FF_SET]) begin
                st_nxt.ff = 1'b1;
              end
              if (mrg[TCCU_FF_CLR]) begin
                st_nxt.ff = 1'b0;
              end
            end
            TCCU_OFF_CMP0: begin
              mrg = tccu_merge(32'(st_r.compare_reg_zero), st_r.wdata, st_r.wstrb);
              st_nxt.compare_reg_zero = mrg[15:0];
            end
            TCCU_OFF_CMP1: begin
              mrg = tccu_merge(32'(st_r.compare_reg_one), st_r.wdata, st_r.wstrb);
              st_nxt.compare_reg_one = mrg[15:0];
            end
            TCCU_OFF_MASK: begin
              mrg = tccu_merge(32'(st_r.mask), st_r.wdata, st_r.wstrb);
              st_nxt.mask = mrg[TCCU_NIRQ-1:0];
            end
            TCCU_OFF_CMP0BUF: begin
              mrg = tccu_merge(32'(st_r.cmp0_buf), st_r.wdata, st_r.wstrb);
              st_nxt.cmp0_buf = mrg[15:0];
            end
            default: begin
              mrg = '0;
            end
          endcase
        end
      end
      TCCU_W_RESP: begin
        if (s_axi_bready) begin
          st_nxt.wst = TCCU_W_IDLE;
        end
      end
      default: begin
        st_nxt.wst = TCCU_W_IDLE;
      end
    endcase

    // ---- read channel
    case (st_r.rst)
      TCCU_R_IDLE: begin
        if (s_axi_arvalid) begin
          case (s_axi_araddr)
            TCCU_OFF_CTRL:    rd = 32'(st_r.ctrl);
            TCCU_OFF_MODE:    rd = 32'(st_r.timer_mode_reg);
            TCCU_OFF_FFCTRL:  rd = 32'({st_r.ff, st_r.flipflop_control});
            TCCU_OFF_CMP0:    rd = 32'(st_r.compare_reg_zero);
            TCCU_OFF_CMP1:    rd = 32'(st_r.compare_reg_one);
            TCCU_OFF_CAP0:    rd = 32'(st_r.capture_reg_zero);
            TCCU_OFF_CAP1:    rd = 32'(st_r.capture_reg_one);
            TCCU_OFF_COUNT:   rd = 32'(st_r.up_counter);
            TCCU_OFF_STATUS: begin
              rd        = 32'(st_r.status);
              rd_status = 1'b1;
            end
            TCCU_OFF_MASK:    rd = 32'(st_r.mask);
            TCCU_OFF_CMP0BUF: rd = 32'(st_r.cmp0_buf);
            default:          rd = '0;
          endcase
          st_nxt.rdata = rd;
          st_nxt.rresp = tccu_mapped(s_axi_araddr) ? TCCU_RESP_OKAY : TCCU_RESP_SLVERR;
          st_nxt.rst   = TCCU_R_DATA;
        end
      end
      TCCU_R_DATA: begin
        if (s_axi_rready) begin
          st_nxt.rst = TCCU_R_IDLE;
        end
      end
      default: begin
        st_nxt.rst = TCCU_R_IDLE;
      end
    endcase

    // sticky status: read clears, a same-cycle event still sets
    if (rd_status) begin
      st_nxt.status = ev;
    end else begin
      st_nxt.status = st_r.status | ev;
    end
    st_nxt.irq = |(st_nxt.status & st_nxt.mask);
  end

  // single register stage for all state
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st_r     <= '0;
      st_r.wst <= TCCU_W_IDLE;
      st_r.rst <= TCCU_R_IDLE;
    end else begin
      st_r <= st_nxt;
    end
  end

  // outputs straight from flip-flops
  assign s_axi_awready   = st_r.wst == TCCU_W_IDLE && !st_r.aw_got;
  assign s_axi_wready    = st_r.wst == TCCU_W_IDLE && !st_r.w_got;
  assign s_axi_bvalid    = st_r.wst == TCCU_W_RESP;
  assign s_axi_bresp     = st_r.bresp;
  assign s_axi_arready   = st_r.rst == TCCU_R_IDLE;
  assign s_axi_rvalid    = st_r.rst == TCCU_R_DATA;
  assign s_axi_rdata     = st_r.rdata;
  assign s_axi_rresp     = st_r.rresp;
  assign output_flipflop = st_r.ff;
  assign irq             = st_r.irq;

endmodule

//--- pkg/tccu_pkg.sv
package tccu_pkg;

  // register byte offsets
  localparam logic [7:0] TCCU_OFF_CTRL    = 8'h00;
  localparam logic [7:0] TCCU_OFF_MODE    = 8'h04;
  localparam logic [7:0] TCCU_OFF_FFCTRL  = 8'h08;
  localparam logic [7:0] TCCU_OFF_CMP0    = 8'h0C;
  localparam logic [7:0] TCCU_OFF_CMP1    = 8'h10;
  localparam logic [7:0] TCCU_OFF_CAP0    = 8'h14;
  localparam logic [7:0] TCCU_OFF_CAP1    = 8'h18;
  localparam logic [7:0] TCCU_OFF_COUNT   = 8'h1C;
  localparam logic [7:0] TCCU_OFF_STATUS  = 8'h20;
  localparam logic [7:0] TCCU_OFF_MASK    = 8'h24;
  localparam logic [7:0] TCCU_OFF_CMP0BUF = 8'h28;

  // control register fields
  localparam int TCCU_CTRL_RUN  = 0;
  localparam int TCCU_CTRL_DBUF = 1;
  localparam int TCCU_CTRL_SWCAP = 2;
  // mode register fields
  localparam int TCCU_MODE_EXTCLK = 0;
  localparam int TCCU_MODE_CPM_LO = 1;
  // flip-flop control fields
  localparam int TCCU_FF_T0   = 0;
  localparam int TCCU_FF_T1   = 1;
  localparam int TCCU_FF_TCAP = 2;
  localparam int TCCU_FF_SET  = 3;
  localparam int TCCU_FF_CLR  = 4;

  // status / mask bits
  localparam int TCCU_IRQ_CAP0  = 0;
  localparam int TCCU_IRQ_CAP1  = 1;
  localparam int TCCU_IRQ_MATCH = 2;
  localparam int TCCU_NIRQ      = 3;

  // prescaler divide ratio, 100 MHz down to the count tick
  localparam logic [7:0] TCCU_PRESC_DIV = 8'h04;

  localparam logic [1:0] TCCU_RESP_OKAY   = 2'h0;
  localparam logic [1:0] TCCU_RESP_SLVERR = 2'h2;

  // capture source selection
  typedef enum logic [1:0] {
    TCCU_CPM_OFF  = 2'h0,
    TCCU_CPM_A_UP = 2'h1,
    TCCU_CPM_A_BOTH = 2'h2,
    TCCU_CPM_GATE = 2'h3
  } tccu_cpm_t;

  // capture event pair
  typedef struct packed {
    logic cap0;
    logic cap1;
  } tccu_capev_t;

  // synchronised pin samples
  typedef struct packed {
    logic a;
    logic b;
    logic evt;
    logic gate;
  } tccu_pins_t;

  typedef enum {TCCU_W_IDLE, TCCU_W_RESP} tccu_wst_t;
  typedef enum {TCCU_R_IDLE, TCCU_R_DATA} tccu_rst_t;

endpackage

//--- core/tccu_sync.sv
`timescale 1ns/100ps
// two-stage synchroniser plus edge history for the external pins
module tccu_sync
  import tccu_pkg::*;
(
  input  wire logic       aclk,
  input  wire logic       aresetn,
  input  wire tccu_pins_t pins_in,
  output tccu_pins_t      pins_sync,
  output tccu_pins_t      pins_rise,
  output tccu_pins_t      pins_fall
);

  // all state of the synchroniser
  typedef struct packed {
    tccu_pins_t s1;    // first stage, read only by s2
    tccu_pins_t s2;    // second stage
    tccu_pins_t prev;  // delayed copy for edge detect
  } tccu_sync_st_t;

  tccu_sync_st_t st_r;
  tccu_sync_st_t st_nxt;

  // shift the pin samples along
  always_comb begin
    st_nxt      = st_r;
    st_nxt.s1   = pins_in;
    st_nxt.s2   = st_r.s1;
    st_nxt.prev = st_r.s2;
  end

  // register stage
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign pins_sync = st_r.s2;
  assign pins_rise = st_r.s2 & ~st_r.prev;
  assign pins_fall = ~st_r.s2 & st_r.prev;

endmodule

//--- dv/tccu_pulse.sv
`timescale 1ns/100ps
// far-side pulse sources: bit 0 input a, bit 1 input b, bit 2 count pin, bit 3 other timer output
module tccu_pulse (
  input  wire logic       aclk,
  input  wire logic       aresetn,
  input  wire logic [3:0] go,
  input  wire logic [7:0] width,
  output logic      [3:0] pins
);
  logic [7:0] left [4];  // cycles still high per pin

  // one request starts one clean high pulse; the level is held, never left floating
  always @(posedge aclk) begin
    for (int i = 0; i < 4; i++) begin
      if (!aresetn) begin
        left[i] <= 8'h00;
        pins[i] <= 1'b0;
      end else if (go[i]) begin
        left[i] <= width;
        pins[i] <= 1'b1;
      end else if (left[i] > 8'h01) begin
        left[i] <= left[i] - 8'h01;
      end else begin
        pins[i] <= 1'b0;
      end
    end
  end
endmodule

//--- dv/tccu_assertions.sv
`timescale 1ns/100ps
// bus handshake and reset checks on the top ports
module tccu_assertions
  import tccu_pkg::*;
(
  input wire logic        aclk,
  input wire logic        aresetn,
  input wire logic [7:0]  s_axi_araddr,
  input wire logic        s_axi_awvalid,
  input wire logic        s_axi_awready,
  input wire logic        s_axi_wvalid,
  input wire logic        s_axi_wready,
  input wire logic [1:0]  s_axi_bresp,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_bready,
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0]  s_axi_rresp,
  input wire logic        s_axi_rvalid,
  input wire logic        s_axi_rready,
  input wire logic        output_flipflop,
  input wire logic        irq
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  aw_refused_a: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("write accepted while a response is pending");
  ar_refused_a: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read accepted while read data is pending");
  bresp_holds_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped before bready");
  rdata_holds_a: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped before rready");
  read_answer_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read data late");
  write_answer_a: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |=> ##1 s_axi_bvalid)
    else $error("write response late");
  unmapped_read_a: assert property (s_axi_arvalid && s_axi_arready && s_axi_araddr > 8'h28
    |=> s_axi_rresp == TCCU_RESP_SLVERR && s_axi_rdata == 32'h0)
    else $error("unmapped read not refused");
  // reset itself is the cause here, so it cannot also disable the check
  reset_idle_a: assert property (disable iff (1'b0) !aresetn |=> !s_axi_bvalid && !s_axi_rvalid && !irq
    && !output_flipflop)
    else $error("outputs not idle after reset");

  cover property (s_axi_bvalid && s_axi_bready);
  cover property ($rose(irq));
  cover property ($changed(output_flipflop));
endmodule
bind tccu_top tccu_assertions tccu_assertions_i (.*);

//--- dv/tccu_tb.sv
`timescale 1ns/100ps
module tccu_tb;
  import tccu_pkg::*;
  typedef struct {logic [7:0] a; logic w; logic [31:0] d; logic [31:0] e; logic [1:0] r;} tccu_row_t;
  logic        aclk, aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready;
  logic [7:0]  s_axi_awaddr, s_axi_araddr, width;
  logic [31:0] s_axi_wdata, s_axi_rdata, v, cnt;
  logic [3:0]  s_axi_wstrb, go, pins;
  logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, output_flipflop, irq;
  logic [1:0]  s_axi_bresp, s_axi_rresp, r;
  logic        capture_input_a, capture_input_b, event_count_input, gating_timer_output;
  int          miscompares, n_compared, cycles, nff;
  // register table: writes to read-only places are ignored, unmapped ones refused
  tccu_row_t rows[8] = '{'{TCCU_OFF_CMP0, 1, 32'h1234, 32'h1234, 2'h0}, '{TCCU_OFF_CMP1, 1, 32'hABCD, 32'hABCD, 2'h0},
    '{TCCU_OFF_MASK, 1, 32'h7, 32'h7, 2'h0}, '{TCCU_OFF_CMP0BUF, 1, 32'h55AA, 32'h55AA, 2'h0},
    '{TCCU_OFF_CAP0, 1, 32'hFFFF, 32'h0, 2'h0}, '{TCCU_OFF_COUNT, 0, 32'h0, 32'h0, 2'h0},
    '{TCCU_OFF_STATUS, 0, 32'h0, 32'h0, 2'h0}, '{8'h30, 1, 32'h1, 32'h0, 2'h2}};

  assign {gating_timer_output, event_count_input, capture_input_b, capture_input_a} = pins;
  tccu_top tccu_top_i (.*);
  tccu_pulse tccu_pulse_i (.aclk(aclk), .aresetn(aresetn), .go(go), .width(width), .pins(pins));

  initial begin
    aclk = 1'b0;
    forever #5 aclk = ~aclk;
  end
  // hang guard: the whole sequence needs under a thousand cycles
  always @(posedge aclk) begin
    cycles++;
    if (cycles == 20000) begin
      miscompares++;
      test_done();
    end
  end
  always @(output_flipflop) nff++;  // counts output inversions

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      miscompares++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask
  // address and data offered together, each released when taken
  task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] resp);
    logic ap, wp;
    ap = 1'b1;
    wp = 1'b1;
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    while (ap || wp) begin
      @(posedge aclk);
      if (ap && s_axi_awready) begin
        ap = 1'b0;
        s_axi_awvalid <= 1'b0;
      end
      if (wp && s_axi_wready) begin
        wp = 1'b0;
        s_axi_wvalid <= 1'b0;
      end
    end
    do @(posedge aclk); while (!s_axi_bvalid);
    resp = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask
  task automatic rd_reg(input logic [7:0] a, output logic [31:0] d, output logic [1:0] resp);
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do @(posedge aclk); while (!s_axi_arready);
    s_axi_arvalid <= 1'b0;
    do @(posedge aclk); while (!s_axi_rvalid);
    d = s_axi_rdata;
    resp = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask
  task automatic pulse(input int i, input logic [7:0] w, input int gap);
    @(posedge aclk);
    width <= w;
    go[i] <= 1'b1;
    @(posedge aclk);
    go[i] <= 1'b0;
    repeat (gap) @(posedge aclk);
  endtask
  // both captures are delayed alike, so their difference is exact in ticks
  task automatic cap_diff(input string what, input logic [31:0] exp);
    logic [31:0] c0;
    rd_reg(TCCU_OFF_CAP0, c0, r);
    rd_reg(TCCU_OFF_CAP1, v, r);
    check(what, v - c0, exp);
    rd_reg(TCCU_OFF_STATUS, v, r);
    check("status", v, 32'h3);
    $display("test %s done", what);
  endtask
  task automatic test_done();
    $display("compared %0d mismatched %0d", n_compared, miscompares);
    if (miscompares == 0 && n_compared > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask

  initial begin
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready, go} = '0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata, width} = '0;
    s_axi_wstrb = 4'hF;
    aresetn = 1'b0;
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    foreach (rows[i]) begin
      if (rows[i].w) begin
        wr(rows[i].a, rows[i].d, r);
        check("bresp", r, rows[i].r);
      end
      rd_reg(rows[i].a, v, r);
      check("rdata", v, rows[i].e);
      check("rresp", r, rows[i].r);
    end
    $display("test registers done");
    wr(TCCU_OFF_MASK, 32'h3, r);
    wr(TCCU_OFF_CTRL, 32'h1, r);
    wr(TCCU_OFF_MODE, 32'h4, r);
    pulse(0, 8'd40, 60);
    check("irq", irq, 1'b1);
    cap_diff("a width", 32'd10);
    @(posedge aclk);
    check("irq clear", irq, 1'b0);
    wr(TCCU_OFF_MODE, 32'h2, r);
    wr(TCCU_OFF_FFCTRL, 32'h14, r);
    // b rises 20 cycles after a, a whole number of count ticks
    pulse(0, 8'd40, 18);
    pulse(1, 8'd40, 60);
    check("ff on capture", output_flipflop, 1'b1);
    cap_diff("a to b", 32'd5);
    wr(TCCU_OFF_FFCTRL, 32'h10, r);
    wr(TCCU_OFF_MODE, 32'h6, r);
    pulse(3, 8'd80, 100);
    cap_diff("gate width", 32'd20);
    wr(TCCU_OFF_MODE, 32'h1, r);
    rd_reg(TCCU_OFF_COUNT, v, r);
    for (int k = 0; k < 5; k++) pulse(2, 8'd4, 8);
    rd_reg(TCCU_OFF_COUNT, cnt, r);
    check("event count", cnt - v, 32'd5);
    // mid-run reset zeroes and stops the counter for the match test
    @(posedge aclk);
    aresetn <= 1'b0;
    repeat (2) @(posedge aclk);
    check("reset ports", {s_axi_awready, s_axi_wready, s_axi_arready, s_axi_bvalid, irq}, 5'h1C);
    aresetn <= 1'b1;
    nff = 0;
    wr(TCCU_OFF_CMP0, 32'h3, r);
    wr(TCCU_OFF_CMP1, 32'h6, r);
    wr(TCCU_OFF_CMP0BUF, 32'h9, r);
    wr(TCCU_OFF_FFCTRL, 32'h13, r);
    wr(TCCU_OFF_MASK, 32'h4, r);
    wr(TCCU_OFF_CTRL, 32'h3, r);
    for (int k = 0; k < 200 && irq !== 1'b1; k++) @(posedge aclk);
    check("toggles", nff, 2);
    wr(TCCU_OFF_FFCTRL, 32'h0, r);
    rd_reg(TCCU_OFF_CMP0, v, r);
    check("cmp0 reload", v, 32'h9);
    rd_reg(TCCU_OFF_STATUS, v, r);
    check("match status", v, 32'h4);
    repeat (300) @(posedge aclk);
    check("no toggles", nff, 2);
    rd_reg(TCCU_OFF_COUNT, v, r);
    check("still counting", v > 32'd60, 1'b1);
    $display("test match done");
    test_done();
  end
endmodule
